/* verilog/ssc_pkg.sv */
// constants for the smi status collector
package ssc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] SSC_IDX_FLAGS_TWO = 6'h11;
    localparam logic [5:0] SSC_IDX_FLAGS_THREE = 6'h12;
    localparam logic [5:0] SSC_IDX_FLAGS_FOUR = 6'h13;
    localparam logic [5:0] SSC_IDX_FLAGS_FIVE = 6'h14;
    localparam logic [5:0] SSC_IDX_RESERVED = 6'h15;
    localparam logic [5:0] SSC_IDX_ENABLE_ONE = 6'h16;
    localparam logic [5:0] SSC_IDX_ENABLE_THREE = 6'h17;
    localparam logic [5:0] SSC_IDX_ENABLE_FOUR = 6'h18;
    localparam logic [5:0] SSC_IDX_ENABLE_FIVE = 6'h19;
    localparam logic [5:0] SSC_IDX_CONFIG = 6'h1A;

    localparam int SSC_ADDR_W = 8;
    localparam int SSC_DATA_W = 32;
    localparam int SSC_REG_W = 8;

    // flags two bit positions
    localparam int SSC_BIT_MOUSE = 0;
    localparam int SSC_BIT_KEYBOARD = 1;
    localparam int SSC_BIT_INFRARED = 2;
    localparam int SSC_BIT_KBC_OUT = 4;
    // flags five bit positions
    localparam int SSC_BIT_FAN_FIRST = 6;
    localparam int SSC_BIT_FAN_SECOND = 7;
    // config bit position
    localparam int SSC_BIT_RX_SELECT = 0;

    // bits that exist in each register
    localparam logic [7:0] SSC_MASK_TWO = 8'h17;
    localparam logic [7:0] SSC_MASK_THREE = 8'hF7;
    localparam logic [7:0] SSC_MASK_FOUR = 8'hFF;
    localparam logic [7:0] SSC_MASK_FIVE = 8'hCF;
    localparam logic [7:0] SSC_MASK_CONFIG = 8'h01;

    localparam logic [7:0] SSC_RESET_FLAGS = 8'h00;
    localparam logic [7:0] SSC_RESET_ENABLE = 8'h00;
    localparam logic [7:0] SSC_RESET_CONFIG = 8'h00;

    localparam logic [1:0] SSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSC_RESP_SLVERR = 2'h2;
endpackage : ssc_pkg

/* verilog/ssc_edge_detect.sv */
// transition detector for the selected infrared receive line
`timescale 1ns/1ps
module ssc_edge_detect (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic level_i,
    output logic edge_o
);
    logic prev_q;
    logic primed_q;

    // no edge reported on the first sample after reset
    assign edge_o = primed_q & (level_i ^ prev_q);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= level_i;
            primed_q <= 1'b1;
        end
    end
endmodule : ssc_edge_detect

/* verilog/ssc_w1c_bank.sv */
// sticky flag byte, set by events, cleared by writing one
`timescale 1ns/1ps
module ssc_w1c_bank import ssc_pkg::*; #(
    parameter logic [7:0] VALID_MASK = 8'hFF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    output logic [7:0] flags_o
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // set wins over a clear in the same cycle
    assign flags_d = ((flags_q & ~clr_i) | set_i) & VALID_MASK;
    assign flags_o = flags_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_q <= SSC_RESET_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule : ssc_w1c_bank

/* verilog/ssc_top.sv */
// smi status collector with axi4-lite register access
`timescale 1ns/1ps
module ssc_top import ssc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // axi4-lite slave
    input wire logic [SSC_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [SSC_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [SSC_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [SSC_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // interrupt sources
    input wire logic mouse_irq_i,
    input wire logic keyboard_irq_i,
    input wire logic kbc_output_i,
    input wire logic infrared_rx_first_i,
    input wire logic infrared_rx_second_i,
    input wire logic [7:0] gp_three_evt_i,
    input wire logic [7:0] gp_four_evt_i,
    input wire logic [3:0] gp_five_evt_i,
    input wire logic fan_speed_in_first_i,
    input wire logic fan_speed_in_second_i,
    // status to the combining logic
    output logic [7:0] smi_flags_two_o,
    output logic [7:0] smi_flags_three_o,
    output logic [7:0] smi_flags_four_o,
    output logic [7:0] smi_flags_five_o,
    output logic smi_request_o
);
    // write channel
    logic aw_full_q;
    logic aw_full_d;
    logic [SSC_ADDR_W-1:0] aw_addr_q;
    logic w_full_q;
    logic w_full_d;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    wire aw_hs = s_axi_awvalid_i & awready_q;
    wire w_hs = s_axi_wvalid_i & wready_q;
    wire b_hs = bvalid_q & s_axi_bready_i;
    wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
    wire [5:0] wr_idx = aw_addr_q[7:2];
    wire wr_en = do_wr & w_lane0_q;

    assign aw_full_d = do_wr ? 1'b0 : (aw_full_q | aw_hs);
    assign w_full_d = do_wr ? 1'b0 : (w_full_q | w_hs);

    // read channel
    logic arready_q;
    logic rvalid_q;
    logic [SSC_DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    wire ar_hs = s_axi_arvalid_i & arready_q;
    wire r_hs = rvalid_q & s_axi_rready_i;
    wire [5:0] rd_idx = s_axi_araddr_i[7:2];

    // register state
    logic [7:0] en_two_q;
    logic [7:0] en_three_q;
    logic [7:0] en_four_q;
    logic [7:0] en_five_q;
    logic [7:0] config_q;
    logic ir_flag_q;
    logic ir_flag_d;
    logic src_mouse_q;
    logic src_keyboard_q;
    logic src_kbc_q;
    logic smi_q;
    logic [7:0] flags_two;
    logic [7:0] flags_three;
    logic [7:0] flags_four;
    logic [7:0] flags_five;

    // address decode
    wire wr_en_two = wr_en & (wr_idx == SSC_IDX_ENABLE_ONE);
    wire wr_en_three = wr_en & (wr_idx == SSC_IDX_ENABLE_THREE);
    wire wr_en_four = wr_en & (wr_idx == SSC_IDX_ENABLE_FOUR);
    wire wr_en_five = wr_en & (wr_idx == SSC_IDX_ENABLE_FIVE);
    wire wr_config = wr_en & (wr_idx == SSC_IDX_CONFIG);
    wire wr_three = wr_en & (wr_idx == SSC_IDX_FLAGS_THREE);
    wire wr_four = wr_en & (wr_idx == SSC_IDX_FLAGS_FOUR);
    wire wr_five = wr_en & (wr_idx == SSC_IDX_FLAGS_FIVE);
    wire wr_mapped = (wr_idx >= SSC_IDX_FLAGS_TWO) & (wr_idx <= SSC_IDX_CONFIG);
    wire rd_mapped = (rd_idx >= SSC_IDX_FLAGS_TWO) & (rd_idx <= SSC_IDX_CONFIG);

    // writes to flags two and the reserved slot are accepted and ignored
    assign bresp_d = wr_mapped ? SSC_RESP_OKAY : SSC_RESP_SLVERR;

    wire [7:0] clr_three = wr_three ? w_byte_q : 8'h00;
    wire [7:0] clr_four = wr_four ? w_byte_q : 8'h00;
    wire [7:0] clr_five = wr_five ? w_byte_q : 8'h00;

    // infrared edge path
    wire ir_sel = config_q[SSC_BIT_RX_SELECT];
    wire ir_muxed = ir_sel ? infrared_rx_second_i : infrared_rx_first_i;
    logic ir_edge;

    ssc_edge_detect u_ir_edge (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .level_i(ir_muxed),
        .edge_o(ir_edge)
    );

    // read of flags two clears, a fresh edge in that cycle wins
    wire ir_rd_clr = ar_hs & (rd_idx == SSC_IDX_FLAGS_TWO);
    assign ir_flag_d = ir_edge | (ir_flag_q & ~ir_rd_clr);

    // flags two assembly
    assign flags_two = {3'h0,
                        src_kbc_q,
                        1'b0,
                        ir_flag_q,
                        src_keyboard_q,
                        src_mouse_q};

    // flags three to five
    wire [7:0] set_three = gp_three_evt_i & SSC_MASK_THREE;
    wire [7:0] set_four = gp_four_evt_i;
    wire [7:0] set_five = {fan_speed_in_second_i,
                           fan_speed_in_first_i,
                           2'h0,
                           gp_five_evt_i};

    ssc_w1c_bank #(
        .VALID_MASK(SSC_MASK_THREE)
    ) u_flags_three (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(set_three),
        .clr_i(clr_three),
        .flags_o(flags_three)
    );

    ssc_w1c_bank #(
        .VALID_MASK(SSC_MASK_FOUR)
    ) u_flags_four (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(set_four),
        .clr_i(clr_four),
        .flags_o(flags_four)
    );

    ssc_w1c_bank #(
        .VALID_MASK(SSC_MASK_FIVE)
    ) u_flags_five (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(set_five),
        .clr_i(clr_five),
        .flags_o(flags_five)
    );

    // read data mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_idx)
            SSC_IDX_FLAGS_TWO: rd_byte = flags_two;
            SSC_IDX_FLAGS_THREE: rd_byte = flags_three;
            SSC_IDX_FLAGS_FOUR: rd_byte = flags_four;
            SSC_IDX_FLAGS_FIVE: rd_byte = flags_five;
            SSC_IDX_RESERVED: rd_byte = 8'h00;
            SSC_IDX_ENABLE_ONE: rd_byte = en_two_q;
            SSC_IDX_ENABLE_THREE: rd_byte = en_three_q;
            SSC_IDX_ENABLE_FOUR: rd_byte = en_four_q;
            SSC_IDX_ENABLE_FIVE: rd_byte = en_five_q;
            SSC_IDX_CONFIG: rd_byte = config_q;
            default: rd_byte = 8'h00;
        endcase
    end

    // smi request
    wire smi_any = |(flags_two & en_two_q)
                 | |(flags_three & en_three_q)
                 | |(flags_four & en_four_q)
                 | |(flags_five & en_five_q);

    // write channel registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_addr_q <= 8'h00;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                w_byte_q <= s_axi_wdata_i[7:0];
                w_lane0_q <= s_axi_wstrb_i[0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= SSC_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= bresp_d;
        end else if (b_hs) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= SSC_RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_mapped ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
        end else if (r_hs) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_two_q <= SSC_RESET_ENABLE;
            en_three_q <= SSC_RESET_ENABLE;
            en_four_q <= SSC_RESET_ENABLE;
            en_five_q <= SSC_RESET_ENABLE;
            config_q <= SSC_RESET_CONFIG;
        end else begin
            if (wr_en_two) begin
                en_two_q <= w_byte_q & SSC_MASK_TWO;
            end
            if (wr_en_three) begin
                en_three_q <= w_byte_q & SSC_MASK_THREE;
            end
            if (wr_en_four) begin
                en_four_q <= w_byte_q & SSC_MASK_FOUR;
            end
            if (wr_en_five) begin
                en_five_q <= w_byte_q & SSC_MASK_FIVE;
            end
            if (wr_config) begin
                config_q <= w_byte_q & SSC_MASK_CONFIG;
            end
        end
    end

    // flag state and outputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_flag_q <= 1'b0;
            src_mouse_q <= 1'b0;
            src_keyboard_q <= 1'b0;
            src_kbc_q <= 1'b0;
            smi_q <= 1'b0;
        end else begin
            ir_flag_q <= ir_flag_d;
            src_mouse_q <= mouse_irq_i;
            src_keyboard_q <= keyboard_irq_i;
            src_kbc_q <= kbc_output_i;
            smi_q <= smi_any;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign smi_flags_two_o = flags_two;
    assign smi_flags_three_o = flags_three;
    assign smi_flags_four_o = flags_four;
    assign smi_flags_five_o = flags_five;
    assign smi_request_o = smi_q;
endmodule : ssc_top

/* tb/ssc_top_sva.sv */
// port assertions for the smi status collector
`timescale 1ns/1ps
module ssc_top_sva import ssc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [SSC_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [SSC_DATA_W-1:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic mouse_irq_i,
    input wire logic kbc_output_i,
    input wire logic infrared_rx_first_i,
    input wire logic infrared_rx_second_i,
    input wire logic [7:0] gp_three_evt_i,
    input wire logic fan_speed_in_second_i,
    input wire logic [7:0] smi_flags_two_o,
    input wire logic [7:0] smi_flags_three_o,
    input wire logic [7:0] smi_flags_four_o,
    input wire logic [7:0] smi_flags_five_o,
    input wire logic smi_request_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence rd_take(idx);
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == idx;
    endsequence
    sequence ir_calm;
        $stable(infrared_rx_first_i) && $past(infrared_rx_first_i, 2) == infrared_rx_first_i
        && $stable(infrared_rx_second_i)
        && $past(infrared_rx_second_i, 2) == infrared_rx_second_i;
    endsequence
    AST_MOUSE_FOLLOW: assert property (mouse_irq_i |=> smi_flags_two_o[0])
        else $error("mouse flag did not follow its source");
    AST_KBC_CLEAR: assert property (!kbc_output_i |=> !smi_flags_two_o[4])
        else $error("kbc output flag stayed set after source cleared");
    AST_RSVD_ZERO: assert property ((smi_flags_two_o & ~SSC_MASK_TWO) == 8'h00
        && (smi_flags_three_o & ~SSC_MASK_THREE) == 8'h00
        && (smi_flags_five_o & ~SSC_MASK_FIVE) == 8'h00)
        else $error("reserved flag bit set");
    AST_IR_READ_CLR: assert property (rd_take(SSC_IDX_FLAGS_TWO) ##0 ir_calm
        |=> !smi_flags_two_o[2])
        else $error("infrared flag survived a read");
    AST_RSVD_READ: assert property (rd_take(SSC_IDX_RESERVED)
        |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0 && s_axi_rresp_o == SSC_RESP_OKAY)
        else $error("reserved slot read not zero");
    AST_GP_THREE_SET: assert property (gp_three_evt_i != 8'h00
        |=> (smi_flags_three_o & $past(gp_three_evt_i))
            == ($past(gp_three_evt_i) & SSC_MASK_THREE))
        else $error("flags three missed an event");
    AST_FAN_SET: assert property (fan_speed_in_second_i |=> smi_flags_five_o[7])
        else $error("second fan flag missed an event");
    AST_REQ_QUIET: assert property ({smi_flags_two_o, smi_flags_three_o,
        smi_flags_four_o, smi_flags_five_o} == 32'h0 |=> !smi_request_o)
        else $error("request without any flag");
    AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
endmodule : ssc_top_sva
bind ssc_top ssc_top_sva u_sva (.*);

/* tb/ssc_top_tb_top.sv */
// self-checking bench for the smi status collector
`timescale 1ns/1ps
module ssc_top_tb_top import ssc_pkg::*;;
    logic clk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, mouse = 1'h0, kbd = 1'h0, kbc = 1'h0;
    logic rx1 = 1'h0, rx2 = 1'h0, fan1 = 1'h0, fan2 = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, g3 = 8'h00, g4 = 8'h00;
    logic [31:0] wdata = 32'h0, t;
    logic [3:0] g5 = 4'h0, wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, req;
    logic [1:0] bresp, rresp, ok;
    logic [31:0] rdata;
    logic [7:0] f2, f3, f4, f5, e3, e4, e5, c;
    int n_fail = 0;
    int compares = 0;
    ssc_top uut (.clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mouse_irq_i(mouse), .keyboard_irq_i(kbd),
        .kbc_output_i(kbc), .infrared_rx_first_i(rx1), .infrared_rx_second_i(rx2),
        .gp_three_evt_i(g3), .gp_four_evt_i(g4), .gp_five_evt_i(g5),
        .fan_speed_in_first_i(fan1), .fan_speed_in_second_i(fan2),
        .smi_flags_two_o(f2), .smi_flags_three_o(f3), .smi_flags_four_o(f4),
        .smi_flags_five_o(f5), .smi_request_o(req));
    always #20 clk = ~clk;
    function automatic logic [7:0] ba(input logic [5:0] i);
        return {i, 2'h0};
    endfunction : ba
    function automatic logic [31:0] exp_two(input logic m, k, p, ir);
        return {27'h0, p, 1'h0, ir, k, m};
    endfunction : exp_two
    task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
        end
    endtask : chk_d
    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t resp %h expected %h", $time, got, exp);
        end
    endtask : chk_r
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid && n < 40);
        chk_d({31'h0, bvalid}, 32'h1);
        chk_r(bresp, er);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (!rvalid && n < 40);
        chk_d({31'h0, rvalid}, 32'h1);
        chk_d(rdata, ed);
        chk_r(rresp, er);
    endtask : rdc
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        t = $urandom(32'h464557AD);
        ok = SSC_RESP_OKAY;
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        bready <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 4; i++) rdc(ba(SSC_IDX_FLAGS_TWO + 6'(i)), 32'h0, ok);
        wr(ba(SSC_IDX_RESERVED), 8'hFF, ok);
        rdc(ba(SSC_IDX_RESERVED), 32'h0, ok);
        rdc(8'hFC, 32'h0, SSC_RESP_SLVERR);
        wr(8'hFC, 8'hFF, SSC_RESP_SLVERR);
        // source-held flags ignore writes
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) {mouse, kbd, kbc} <= (i == 0) ? 3'h7 : 3'($urandom);
            wt(1);
            chk_d({24'h0, f2}, exp_two(mouse, kbd, kbc, 1'h0));
            wr(ba(SSC_IDX_FLAGS_TWO), 8'hFF, ok);
            rdc(ba(SSC_IDX_FLAGS_TWO), exp_two(mouse, kbd, kbc, 1'h0), ok);
        end
        @(posedge clk) {mouse, kbd, kbc} <= 3'h0;
        // infrared edges, read clear, pin select
        wr(ba(SSC_IDX_CONFIG), 8'h00, ok);
        @(posedge clk) rx1 <= 1'h1;
        wt(3);
        chk_d({24'h0, f2}, 32'h4);
        rdc(ba(SSC_IDX_FLAGS_TWO), 32'h4, ok);
        wt(1);
        chk_d({24'h0, f2}, 32'h0);
        @(posedge clk) rx1 <= 1'h0;
        wt(3);
        rdc(ba(SSC_IDX_FLAGS_TWO), 32'h4, ok);
        wr(ba(SSC_IDX_CONFIG), 8'h01, ok);
        @(posedge clk) rx1 <= 1'h1;
        wt(3);
        chk_d({24'h0, f2}, 32'h0);
        @(posedge clk) rx2 <= 1'h1;
        wt(3);
        rdc(ba(SSC_IDX_FLAGS_TWO), 32'h4, ok);
        rdc(ba(SSC_IDX_FLAGS_TWO), 32'h0, ok);
        // pin and fan events, write-one clear
        e3 = 8'h00;
        e4 = 8'h00;
        e5 = 8'h00;
        for (int i = 0; i < 6; i++) begin
            t = $urandom;
            @(posedge clk) {fan2, fan1, g5, g4, g3} <= t[21:0];
            e3 = e3 | (t[7:0] & SSC_MASK_THREE);
            e4 = e4 | t[15:8];
            e5 = e5 | {t[21:20], 2'h0, t[19:16]};
            @(posedge clk) {fan2, fan1, g5, g4, g3} <= 22'h0;
            wt(1);
            chk_d({24'h0, f3}, {24'h0, e3});
            chk_d({24'h0, f4}, {24'h0, e4});
            chk_d({24'h0, f5}, {24'h0, e5});
            c = (i == 0) ? 8'h00 : (i == 5) ? 8'hFF : 8'($urandom);
            wr(ba(SSC_IDX_FLAGS_THREE), c, ok);
            wr(ba(SSC_IDX_FLAGS_FOUR), c, ok);
            wr(ba(SSC_IDX_FLAGS_FIVE), c, ok);
            e3 = e3 & ~c;
            e4 = e4 & ~c;
            e5 = e5 & ~c;
            rdc(ba(SSC_IDX_FLAGS_THREE), {24'h0, e3}, ok);
            rdc(ba(SSC_IDX_FLAGS_FOUR), {24'h0, e4}, ok);
            rdc(ba(SSC_IDX_FLAGS_FIVE), {24'h0, e5}, ok);
        end
        // enables gate the request
        wr(ba(SSC_IDX_ENABLE_ONE), 8'h01, ok);
        @(posedge clk) mouse <= 1'h1;
        wt(2);
        chk_d({31'h0, req}, 32'h1);
        @(posedge clk) mouse <= 1'h0;
        g3 <= 8'h01;
        @(posedge clk) g3 <= 8'h00;
        wt(2);
        chk_d({31'h0, req}, 32'h0);
        wr(ba(SSC_IDX_ENABLE_THREE), 8'h01, ok);
        wt(2);
        chk_d({31'h0, req}, 32'h1);
        // enable and config readback through their write masks
        wr(ba(SSC_IDX_ENABLE_ONE), 8'hFF, ok);
        rdc(ba(SSC_IDX_ENABLE_ONE), {24'h0, SSC_MASK_TWO}, ok);
        wr(ba(SSC_IDX_ENABLE_FIVE), 8'hFF, ok);
        rdc(ba(SSC_IDX_ENABLE_FIVE), {24'h0, SSC_MASK_FIVE}, ok);
        wr(ba(SSC_IDX_CONFIG), 8'hFF, ok);
        rdc(ba(SSC_IDX_CONFIG), {24'h0, SSC_MASK_CONFIG}, ok);
        // lane zero strobe low: write accepted and ignored
        @(posedge clk) wstrb <= 4'h0;
        wr(ba(SSC_IDX_ENABLE_FOUR), 8'hFF, ok);
        rdc(ba(SSC_IDX_ENABLE_FOUR), {24'h0, SSC_RESET_ENABLE}, ok);
        give_verdict();
    end
endmodule : ssc_top_tb_top
